// File: verilog/tx_cmd_params.svh
// constants for the transmit command decoder
`ifndef TX_CMD_PARAMS_SVH
`define TX_CMD_PARAMS_SVH
`define CMD_IOC_BIT 31
`define CMD_ALIGN_HI 25
`define CMD_ALIGN_LO 24
`define CMD_OFS_HI 20
`define CMD_OFS_LO 16
`define CMD_FIRST_BIT 13
`define CMD_LAST_BIT 12
`define CMD_SIZE_HI 10
`define CMD_SIZE_LO 0
`define ALIGN_4 2'h0
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2
`define ALIGN_RSVD 2'h3
`endif

// File: verilog/tx_cmd_pkg.sv
// types for the transmit command decoder
package tx_cmd_pkg;
   typedef enum logic [1:0]
   {
      st_cmd_a = 2'h0,
      st_cmd_b = 2'h1,
      st_data = 2'h2
   } phase_type;
endpackage

// File: verilog/skid_buffer.sv
// two-entry buffer with valid and ready on both sides
module skid_buffer #(
   parameter int WIDTH = 32
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   typedef struct packed {
      logic [WIDTH-1:0] d0;
      logic [WIDTH-1:0] d1;
      logic [1:0] cnt;
   } buf_type;
   buf_type s_r;
   buf_type s_nxt;
   logic push;
   logic pop;

   assign in_ready = (s_r.cnt != 2'h2);
   assign out_valid = (s_r.cnt != 2'h0);
   assign out_data = s_r.d0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      s_nxt = s_r;
      if (pop)
      begin
         s_nxt.d0 = s_r.d1;
      end
      if (push)
      begin
         if ((s_r.cnt == 2'h0) || (s_r.cnt == 2'h1 && pop))
         begin
            s_nxt.d0 = in_data;
         end
         else
         begin
            s_nxt.d1 = in_data;
         end
      end
      s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
      if (!rst_n)
      begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      s_r <= s_nxt;
   end
endmodule

// File: verilog/tx_buffer_command_decoder.sv
// transmit command decoder: parses command words, strips offset and padding, checks length
`include "tx_cmd_params.svh"
module tx_buffer_command_decoder #(
   parameter int LEN_W = 11
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] host_data,
   input wire logic host_valid,
   output logic host_ready,
   output logic [31:0] tx_word,
   output logic [3:0] tx_byte_en,
   output logic tx_last,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic tx_completion_interrupt,
   output logic transmit_error_flag,
   output logic first_segment_flag,
   output logic last_segment_flag,
   output logic [1:0] end_alignment,
   output logic align_reserved,
   input wire logic tx_completion_clear,
   input wire logic transmit_error_clear
);
   typedef struct packed {
      tx_cmd_pkg::phase_type phase;
      logic [31:0] cmd_a;
      logic [31:0] cmd_b;
      logic [31:0] ref_b;
      logic have_ref;
      logic [15:0] pos;
      logic [15:0] total;
      logic [15:0] endpos;
      logic [15:0] buf_end;
      logic ioc_pend;
      logic cmpl;
      logic err;
   } state_type;
   state_type s_r;
   state_type s_nxt;
   logic [36:0] in_d;
   logic in_v;
   logic in_rdy;
   logic [36:0] out_d;
   logic accept;
   logic [4:0] ofs;
   logic [15:0] size16;
   logic [15:0] align_mask;
   logic [15:0] lo;
   logic [15:0] wend;
   logic [3:0] be;
   logic [3:0] lane;

   assign ofs = s_r.cmd_a[`CMD_OFS_HI:`CMD_OFS_LO];
   assign size16 = {5'h0, s_r.cmd_a[`CMD_SIZE_HI:`CMD_SIZE_LO]};
   assign first_segment_flag = s_r.cmd_a[`CMD_FIRST_BIT];
   assign last_segment_flag = s_r.cmd_a[`CMD_LAST_BIT];
   assign end_alignment = s_r.cmd_a[`CMD_ALIGN_HI:`CMD_ALIGN_LO];
   assign align_reserved = (end_alignment == `ALIGN_RSVD);
   assign tx_completion_interrupt = s_r.cmpl;
   assign transmit_error_flag = s_r.err;

   always_comb
   begin
      unique case (end_alignment)
         `ALIGN_16: align_mask = 16'h000f;
         `ALIGN_32: align_mask = 16'h001f;
         default: align_mask = 16'h0003;
      endcase
   end

   // byte positions inside the current word, relative to buffer start
   assign lo = {s_r.pos[13:0], 2'h0};
   assign wend = lo + 16'h0004;
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         lane[i] = ((lo + 16'(i)) >= {11'h0, ofs}) && ((lo + 16'(i)) < s_r.endpos);
      end
      be = lane;
   end

   // word accepted from host: in the data phase only if the buffer can take it, so stall reaches the host
   assign host_ready = (s_r.phase != tx_cmd_pkg::st_data) ? 1'b1 : in_rdy;
   assign accept = host_valid && host_ready;

   always_comb
   begin
      in_v = 1'b0;
      in_d = {be, (wend >= s_r.endpos) && s_r.cmd_a[`CMD_LAST_BIT], host_data};
      s_nxt = s_r;
      if (tx_completion_clear)
      begin
         s_nxt.cmpl = 1'b0;
      end
      if (transmit_error_clear)
      begin
         s_nxt.err = 1'b0;
      end
      unique case (s_r.phase)
         tx_cmd_pkg::st_cmd_a:
         begin
            if (accept)
            begin
               s_nxt.cmd_a = host_data;
               s_nxt.phase = tx_cmd_pkg::st_cmd_b;
            end
         end
         tx_cmd_pkg::st_cmd_b:
         begin
            if (accept)
            begin
               s_nxt.cmd_b = host_data;
               s_nxt.pos = 16'h0000;
               s_nxt.endpos = {11'h0, ofs} + size16;
               // padded end: round up to the alignment boundary
               s_nxt.buf_end = (({11'h0, ofs} + size16 + align_mask) & ~align_mask);
               s_nxt.ioc_pend = s_r.cmd_a[`CMD_IOC_BIT];
               if (s_r.cmd_a[`CMD_FIRST_BIT])
               begin
                  s_nxt.total = size16;
                  s_nxt.ref_b = host_data;
                  s_nxt.have_ref = 1'b1;
               end
               else
               begin
                  s_nxt.total = s_r.total + size16;
                  if (s_r.have_ref && (host_data != s_r.ref_b))
                  begin
                     s_nxt.err = 1'b1;
                  end
               end
               s_nxt.phase = tx_cmd_pkg::st_data;
               if (s_nxt.buf_end == 16'h0000)
               begin
                  // empty buffer: no data words follow, so it is complete here
                  s_nxt.phase = tx_cmd_pkg::st_cmd_a;
                  if (s_r.cmd_a[`CMD_IOC_BIT])
                  begin
                     s_nxt.cmpl = 1'b1;
                  end
                  if (s_r.cmd_a[`CMD_LAST_BIT])
                  begin
                     s_nxt.have_ref = 1'b0;
                     if (s_nxt.total[LEN_W-1:0] != host_data[`CMD_SIZE_HI:`CMD_SIZE_LO])
                     begin
                        s_nxt.err = 1'b1;
                     end
                  end
               end
            end
         end
         tx_cmd_pkg::st_data:
         begin
            if (accept)
            begin
               // whole words outside the valid span never enter the buffer
               in_v = (be != 4'h0);
               s_nxt.pos = s_r.pos + 16'h0001;
               if (wend >= s_r.buf_end)
               begin
                  s_nxt.phase = tx_cmd_pkg::st_cmd_a;
                  if (s_r.ioc_pend)
                  begin
                     s_nxt.cmpl = 1'b1;
                  end
                  if (s_r.cmd_a[`CMD_LAST_BIT])
                  begin
                     s_nxt.have_ref = 1'b0;
                     if (s_r.total[LEN_W-1:0] != s_r.cmd_b[`CMD_SIZE_HI:`CMD_SIZE_LO])
                     begin
                        s_nxt.err = 1'b1;
                     end
                  end
               end
            end
         end
         default:
         begin
            s_nxt.phase = tx_cmd_pkg::st_cmd_a;
         end
      endcase
      if (!rst_n)
      begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      s_r <= s_nxt;
   end

   skid_buffer #(
      .WIDTH(37)
   ) u_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_data(in_d),
      .in_valid(in_v),
      .in_ready(in_rdy),
      .out_data(out_d),
      .out_valid(tx_valid),
      .out_ready(tx_ready)
   );
   assign tx_word = out_d[31:0];
   assign tx_last = out_d[32];
   assign tx_byte_en = out_d[36:33];
endmodule

// File: dv/tx_cmd_monitor.sv
// port checker for the transmit command decoder
module tx_cmd_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic host_ready,
   input wire logic [31:0] tx_word,
   input wire logic [3:0] tx_byte_en,
   input wire logic tx_last,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic tx_completion_interrupt,
   input wire logic transmit_error_flag,
   input wire logic [1:0] end_alignment,
   input wire logic align_reserved,
   input wire logic tx_completion_clear,
   input wire logic transmit_error_clear
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence stalled;
      tx_valid && !tx_ready;
   endsequence
   sequence held;
      tx_valid && $stable(tx_word) && $stable(tx_byte_en) && $stable(tx_last);
   endsequence
   stall_hold_a: assert property (stalled |=> held)
      else $error("word moved in stall");
   err_sticky_a: assert property (transmit_error_flag && !transmit_error_clear |=> transmit_error_flag)
      else $error("error flag lost");
   cmpl_sticky_a: assert property (tx_completion_interrupt && !tx_completion_clear |=> tx_completion_interrupt)
      else $error("done flag lost");
   err_clear_a: assert property ($fell(transmit_error_flag) |-> $past(transmit_error_clear))
      else $error("error flag fell alone");
   rsvd_code_a: assert property (align_reserved == (end_alignment == 2'h3))
      else $error("reserved code wrong");
   lane_some_a: assert property (tx_valid |-> tx_byte_en != 4'h0)
      else $error("empty word sent");
   lane_run_a: assert property (tx_valid |-> tx_byte_en inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF})
      else $error("lanes not contiguous");
   ready_empty_a: assert property (!tx_valid |-> host_ready)
      else $error("refused while empty");
endmodule
bind tx_buffer_command_decoder tx_cmd_monitor i_mon (.*);

// File: dv/host_model.sv
// host model writing command and buffer words
module host_model (
   input wire logic clk_sys,
   input wire logic host_ready,
   output logic [31:0] host_data,
   output logic host_valid,
   output logic hung
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {host_valid, hung, host_data} = '0;
   task send(input logic [31:0] w);
      int n;
      @(negedge clk_sys);
      host_data = w;
      host_valid = 1'b1;
      for (n = 0; n < 40 && !host_ready; n++)
         @(negedge clk_sys);
      hung = n == 40;
      @(posedge clk_sys);
   endtask
   // released bus must not look like a fresh word
   task idle;
      @(negedge clk_sys);
      host_valid = 1'b0;
      host_data = ~host_data;
   endtask
endmodule

// File: dv/tb_tx_buffer_command_decoder.sv
// bench for the transmit command decoder
module tb_tx_buffer_command_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst_n = 0, tx_ready = 0, hung;
   logic tx_completion_clear = 0, transmit_error_clear = 0;
   logic [31:0] host_data, tx_word;
   logic host_valid, host_ready, tx_last, tx_valid, align_reserved;
   logic tx_completion_interrupt, transmit_error_flag, first_segment_flag, last_segment_flag;
   logic [3:0] tx_byte_en;
   logic [1:0] end_alignment;
   logic [36:0] q[$];
   int fail_count = 0, checks_done = 0;
   always #4 clk_sys = ~clk_sys;
   tx_buffer_command_decoder i_dut (.*);
   host_model i_host (.*);
   // dead lanes masked: their content is left open
   always @(posedge clk_sys)
      if (tx_valid === 1'b1 && tx_ready)
         q.push_back({tx_last, tx_byte_en,
            tx_word & {{8{tx_byte_en[3]}}, {8{tx_byte_en[2]}}, {8{tx_byte_en[1]}}, {8{tx_byte_en[0]}}}});
   task chk(input logic [36:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         fail_count++;
         $display("wrong value %0t %h %h", $time, s, e);
      end
   endtask
   task stop_test;
      $display("fails %0d checks %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task snd(input logic [31:0] w);
      i_host.send(w);
      if (hung)
      begin
         fail_count++;
         stop_test;
      end
   endtask
   task run(input logic [31:0] a, b, input int n);
      q.delete();
      snd(a);
      snd(b);
      for (int i = 1; i <= n; i++)
         snd(32'h1111_1111 * i);
      i_host.idle;
   endtask
   task drain(input int n);
      @(negedge clk_sys);
      for (int i = 0; i < 40 && q.size() < n; i++)
         @(negedge clk_sys);
      chk(q.size(), n);
      if (q.size() != n)
         stop_test;
   endtask
   task t_stall;
      fork
         run(32'h0001_300A, 32'h0000_000A, 3);
         begin
            repeat (8) @(negedge clk_sys);
            chk(host_ready, 1'b0);
            tx_ready = 1'b1;
         end
      join
      drain(3);
      chk(q[0], {1'b0, 4'hE, 32'h1111_1100});
      chk(q[1], {1'b0, 4'hF, 32'h2222_2222});
      chk(q[2], {1'b1, 4'h7, 32'h0033_3333});
      chk(transmit_error_flag, 1'b0);
   endtask
   task t_pad;
      run(32'h8100_3004, 32'h0000_0005, 4);
      drain(1);
      chk(q[0], {1'b1, 4'hF, 32'h1111_1111});
      chk({end_alignment, first_segment_flag}, 3'h3);
      chk(tx_completion_interrupt, 1'b1);
      chk(transmit_error_flag, 1'b1);
      tx_completion_clear = 1'b1;
      transmit_error_clear = 1'b1;
      @(negedge clk_sys);
      tx_completion_clear = 1'b0;
      transmit_error_clear = 1'b0;
      chk({tx_completion_interrupt, transmit_error_flag}, 2'h0);
   endtask
   task t_seg;
      run(32'h0305_2003, 32'h0000_0005, 2);
      drain(1);
      chk(q[0], {1'b0, 4'hE, 32'h2222_2200});
      chk({align_reserved, last_segment_flag}, 2'h2);
      run(32'h0000_1002, 32'h0000_0005, 1);
      drain(1);
      chk(q[0], {1'b1, 4'h3, 32'h0000_1111});
      chk(transmit_error_flag, 1'b0);
   endtask
   // 32-byte end alignment, then a last segment whose second word differs
   task t_mix;
      run(32'h0200_2004, 32'h0000_0008, 8);
      drain(1);
      chk(q[0], {1'b0, 4'hF, 32'h1111_1111});
      chk({end_alignment, transmit_error_flag, tx_completion_interrupt}, 4'h8);
      run(32'h0000_1004, 32'h0001_0008, 1);
      drain(1);
      chk(q[0], {1'b1, 4'hF, 32'h1111_1111});
      chk(transmit_error_flag, 1'b1);
   endtask
   initial
   begin
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      t_stall;
      t_pad;
      t_seg;
      t_mix;
      stop_test;
   end
endmodule
